// *** logic/rcss_baud_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rcss_cfg.svh"

module rcss_baud_gen
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic enable_in,
  output logic tick_out
);

  localparam logic [11:0] DIV_LAST = 12'(`RCSS_BAUD_DIV - 1);

  logic [11:0] cnt;
  logic [11:0] next_cnt;
  logic next_tick;

  // one tick per bit time; counter parks at zero while off
  always_comb
  begin
    next_cnt = 12'h000;
    next_tick = 1'b0;
    if (enable_in)
    begin
      if (cnt == DIV_LAST)
      begin
        next_tick = 1'b1;
      end
      else
      begin
        next_cnt = cnt + 12'h001;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cnt <= 12'h000;
      tick_out <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      tick_out <= next_tick;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  bit_period_a: assert property (tick_out |-> $past(cnt) == DIV_LAST)
    else $error("bit tick not at divider end");
  tick_single_a: assert property (tick_out |=> !tick_out [*8])
    else $error("bit ticks too close");

endmodule

`default_nettype wire

// *** logic/rcss_cfg.svh ***
`ifndef RCSS_CFG_SVH
`define RCSS_CFG_SVH

// ****************************************************************
// timing
// ****************************************************************
`define RCSS_CLK_HZ 20000000
`define RCSS_SERIAL_BPS 9600
`define RCSS_BAUD_DIV (`RCSS_CLK_HZ / `RCSS_SERIAL_BPS)

// ****************************************************************
// register byte offsets
// ****************************************************************
`define RCSS_OFS_CFG 8'h00
`define RCSS_OFS_GAIN_PRI 8'h04
`define RCSS_OFS_GAIN_SEC 8'h08
`define RCSS_OFS_STATUS 8'h0c

// ****************************************************************
// config word fields
// ****************************************************************
`define RCSS_CFG_SPEED_EN 0
`define RCSS_CFG_DISABLE_EN 1
`define RCSS_CFG_DIR_EN 2
`define RCSS_CFG_JOG_EN 3
`define RCSS_CFG_AUX_LO 4
`define RCSS_CFG_SERIAL_EN 8
`define RCSS_CFG_FB_LO 9
`define RCSS_CFG_LOSS_LO 12
`define RCSS_CFG_NODE_LO 16

// ****************************************************************
// status word fields
// ****************************************************************
`define RCSS_ST_BUS_LOSS 0
`define RCSS_ST_SRC_LO 1
`define RCSS_ST_SEC_GAIN 3
`define RCSS_ST_SERIAL 4
`define RCSS_ST_FIELDBUS 5
`define RCSS_ST_CMD_LO 6

// ****************************************************************
// codes and reset values
// ****************************************************************
`define RCSS_AUX_GAINS 2'h0
`define RCSS_AUX_SERIAL 2'h1
`define RCSS_AUX_SPECIAL 2'h2
`define RCSS_AUX_FIELDBUS 2'h3
`define RCSS_LOSS_RAMP 2'h0
`define RCSS_LOSS_GENERAL 2'h1
`define RCSS_LOSS_NONE 2'h2
`define RCSS_FB_MAX 3'h6
`define RCSS_NODE_RESET 5'h01
`define RCSS_GAIN_RESET 32'h0000_0000

`endif

// *** logic/rcss_pkg.sv ***
`default_nettype none

package rcss_pkg;

  // ****************************************************************
  // drive command bundle
  // ****************************************************************
  typedef struct packed {
    logic general_disable;
    logic ramp_disable;
    logic fault_reset;
    logic direction;
    logic jog_fwd;
    logic jog_rev;
  } rcss_cmd_t;

  // ****************************************************************
  // configuration held by software
  // ****************************************************************
  typedef struct packed {
    logic speed_ref_remote_enable;
    logic disable_cmd_remote_enable;
    logic direction_remote_enable;
    logic jog_remote_enable;
    logic [1:0] aux_input_function;
    logic serial_link_enable;
    logic [2:0] fieldbus_select;
    logic [1:0] bus_loss_action;
    logic [4:0] node_address;
  } rcss_cfg_t;

  typedef enum logic [1:0] {
    RCSS_SRC_DI,
    RCSS_SRC_SERIAL,
    RCSS_SRC_FIELDBUS
  } rcss_src_t;

endpackage

`default_nettype wire

// *** logic/rcss_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rcss_cfg.svh"

module rcss_top
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  input wire rcss_pkg::rcss_cmd_t di_cmd_in,
  input wire logic [15:0] di_speed_ref_in,
  input wire logic di_release_in,
  input wire rcss_pkg::rcss_cmd_t serial_cmd_in,
  input wire logic [15:0] serial_speed_ref_in,
  input wire rcss_pkg::rcss_cmd_t fieldbus_cmd_in,
  input wire logic [15:0] fieldbus_speed_ref_in,
  input wire logic fieldbus_link_up_in,
  input wire logic aux_digital_input_in,
  output rcss_pkg::rcss_cmd_t drive_cmd_out,
  output logic [15:0] speed_ref_out,
  output rcss_pkg::rcss_src_t cmd_source_out,
  output logic secondary_gains_out,
  output logic [15:0] gain_prop_out,
  output logic [15:0] gain_integral_out,
  output logic serial_bit_tick_out,
  output logic serial_link_active_out,
  output logic fieldbus_active_out,
  output logic [2:0] fieldbus_variant_out,
  output logic [4:0] node_address_out,
  output logic bus_loss_fault_out
);

  // ****************************************************************
  // bus slave state
  // ****************************************************************
  rcss_pkg::rcss_cfg_t cfg, next_cfg;
  logic [31:0] gain_pri, next_gain_pri;
  logic [31:0] gain_sec, next_gain_sec;
  logic wr_pend, next_wr_pend;
  logic [7:0] wr_addr, next_wr_addr;
  logic [31:0] next_hrdata;
  logic loss_clear;
  logic [31:0] status_word;
  logic addr_phase;

  // zero wait states: every transfer completes in its first data cycle
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign addr_phase = hsel_in && htrans_in[1] && hready_in;

  // write data lands one cycle after its address phase
  always_comb
  begin
    next_cfg = cfg;
    next_gain_pri = gain_pri;
    next_gain_sec = gain_sec;
    loss_clear = 1'b0;
    next_wr_pend = addr_phase && hwrite_in;
    next_wr_addr = addr_phase ? haddr_in[7:0] : wr_addr;
    if (wr_pend)
      unique case (wr_addr)
        `RCSS_OFS_CFG:
        begin
          next_cfg.speed_ref_remote_enable = hwdata_in[`RCSS_CFG_SPEED_EN];
          next_cfg.disable_cmd_remote_enable = hwdata_in[`RCSS_CFG_DISABLE_EN];
          next_cfg.direction_remote_enable = hwdata_in[`RCSS_CFG_DIR_EN];
          next_cfg.jog_remote_enable = hwdata_in[`RCSS_CFG_JOG_EN];
          next_cfg.aux_input_function = hwdata_in[`RCSS_CFG_AUX_LO +: 2];
          next_cfg.serial_link_enable = hwdata_in[`RCSS_CFG_SERIAL_EN];
          // out-of-range variants are refused, keeping the old choice
          if (hwdata_in[`RCSS_CFG_FB_LO +: 3] <= `RCSS_FB_MAX)
            next_cfg.fieldbus_select = hwdata_in[`RCSS_CFG_FB_LO +: 3];
          next_cfg.bus_loss_action = hwdata_in[`RCSS_CFG_LOSS_LO +: 2];
          next_cfg.node_address = hwdata_in[`RCSS_CFG_NODE_LO +: 5];
        end
        `RCSS_OFS_GAIN_PRI: next_gain_pri = hwdata_in;
        `RCSS_OFS_GAIN_SEC: next_gain_sec = hwdata_in;
        `RCSS_OFS_STATUS: loss_clear = hwdata_in[`RCSS_ST_BUS_LOSS];
        default: ;
      endcase
  end

  // read data sampled at the address phase from the forwarded values,
  // so a read right behind a config or gain write sees the new contents
  always_comb
  begin
    next_hrdata = 32'h0000_0000;
    if (addr_phase && !hwrite_in)
      unique case (haddr_in[7:0])
        `RCSS_OFS_CFG:
        begin
          next_hrdata[`RCSS_CFG_SPEED_EN] = next_cfg.speed_ref_remote_enable;
          next_hrdata[`RCSS_CFG_DISABLE_EN] = next_cfg.disable_cmd_remote_enable;
          next_hrdata[`RCSS_CFG_DIR_EN] = next_cfg.direction_remote_enable;
          next_hrdata[`RCSS_CFG_JOG_EN] = next_cfg.jog_remote_enable;
          next_hrdata[`RCSS_CFG_AUX_LO +: 2] = next_cfg.aux_input_function;
          next_hrdata[`RCSS_CFG_SERIAL_EN] = next_cfg.serial_link_enable;
          next_hrdata[`RCSS_CFG_FB_LO +: 3] = next_cfg.fieldbus_select;
          next_hrdata[`RCSS_CFG_LOSS_LO +: 2] = next_cfg.bus_loss_action;
          next_hrdata[`RCSS_CFG_NODE_LO +: 5] = next_cfg.node_address;
        end
        `RCSS_OFS_GAIN_PRI: next_hrdata = next_gain_pri;
        `RCSS_OFS_GAIN_SEC: next_hrdata = next_gain_sec;
        `RCSS_OFS_STATUS: next_hrdata = status_word;
        default: next_hrdata = 32'h0000_0000;
      endcase
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cfg <= '{node_address: `RCSS_NODE_RESET, default: '0};
      gain_pri <= `RCSS_GAIN_RESET;
      gain_sec <= `RCSS_GAIN_RESET;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata_out <= 32'h0000_0000;
    end
    else
    begin
      cfg <= next_cfg;
      gain_pri <= next_gain_pri;
      gain_sec <= next_gain_sec;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata_out <= next_hrdata;
    end
  end

  // ****************************************************************
  // fieldbus loss flag
  // ****************************************************************
  logic fb_active, next_loss;

  assign fb_active = cfg.fieldbus_select != 3'h0;

  // a drop in the same cycle as a clear keeps the flag set
  always_comb
  begin
    next_loss = bus_loss_fault_out && !loss_clear;
    if (fb_active && !fieldbus_link_up_in)
      next_loss = 1'b1;
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      bus_loss_fault_out <= 1'b0;
    end
    else
    begin
      bus_loss_fault_out <= next_loss;
    end
  end

  // ****************************************************************
  // source and gain selection
  // ****************************************************************
  rcss_pkg::rcss_src_t src;
  rcss_pkg::rcss_cmd_t remote_cmd, next_cmd;
  logic [15:0] remote_ref, next_ref;
  logic next_sec, remote;

  // aux function two leaves both source and gains at their defaults
  always_comb
  begin
    src = rcss_pkg::RCSS_SRC_DI;
    next_sec = 1'b0;
    unique case (cfg.aux_input_function)
      `RCSS_AUX_GAINS: next_sec = aux_digital_input_in;
      `RCSS_AUX_SERIAL:
        if (aux_digital_input_in)
          src = rcss_pkg::RCSS_SRC_SERIAL;
      `RCSS_AUX_SPECIAL: ;
      `RCSS_AUX_FIELDBUS:
        if (aux_digital_input_in)
          src = rcss_pkg::RCSS_SRC_FIELDBUS;
    endcase
  end

  assign remote = src != rcss_pkg::RCSS_SRC_DI;
  assign remote_cmd = (src == rcss_pkg::RCSS_SRC_SERIAL) ? serial_cmd_in : fieldbus_cmd_in;
  assign remote_ref =
    (src == rcss_pkg::RCSS_SRC_SERIAL) ? serial_speed_ref_in : fieldbus_speed_ref_in;

  // each group picks remote only when its own enable allows it
  always_comb
  begin
    next_cmd = di_cmd_in;
    next_ref = di_speed_ref_in;
    if (remote && cfg.speed_ref_remote_enable)
      next_ref = remote_ref;
    if (remote && cfg.disable_cmd_remote_enable)
    begin
      next_cmd.general_disable = remote_cmd.general_disable;
      next_cmd.ramp_disable = remote_cmd.ramp_disable;
      next_cmd.fault_reset = remote_cmd.fault_reset;
    end
    if (remote && cfg.direction_remote_enable)
      next_cmd.direction = remote_cmd.direction;
    if (remote && cfg.jog_remote_enable)
    begin
      next_cmd.jog_fwd = remote_cmd.jog_fwd;
      next_cmd.jog_rev = remote_cmd.jog_rev;
    end
    // the hardwired release stays in charge even under remote control
    if (!di_release_in)
      next_cmd.general_disable = 1'b1;
    if (bus_loss_fault_out)
      unique case (cfg.bus_loss_action)
        `RCSS_LOSS_RAMP: next_cmd.ramp_disable = 1'b1;
        `RCSS_LOSS_GENERAL: next_cmd.general_disable = 1'b1;
        default: ; // none, and the unused code, take no action
      endcase
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      drive_cmd_out <= '{general_disable: 1'b1, default: 1'b0};
      speed_ref_out <= 16'h0000;
      cmd_source_out <= rcss_pkg::RCSS_SRC_DI;
      secondary_gains_out <= 1'b0;
      gain_prop_out <= 16'h0000;
      gain_integral_out <= 16'h0000;
    end
    else
    begin
      drive_cmd_out <= next_cmd;
      speed_ref_out <= next_ref;
      cmd_source_out <= src;
      secondary_gains_out <= next_sec;
      gain_prop_out <= next_sec ? gain_sec[15:0] : gain_pri[15:0];
      gain_integral_out <= next_sec ? gain_sec[31:16] : gain_pri[31:16];
    end
  end

  // ****************************************************************
  // link status and bit timing
  // ****************************************************************
  assign serial_link_active_out = cfg.serial_link_enable;
  assign fieldbus_active_out = fb_active;
  assign fieldbus_variant_out = cfg.fieldbus_select;
  assign node_address_out = cfg.node_address;

  rcss_baud_gen u_baud
  (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .enable_in(cfg.serial_link_enable),
    .tick_out(serial_bit_tick_out)
  );

  // status word, read-only except the bus loss clear bit
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[`RCSS_ST_BUS_LOSS] = bus_loss_fault_out;
    status_word[`RCSS_ST_SRC_LO +: 2] = cmd_source_out;
    status_word[`RCSS_ST_SEC_GAIN] = secondary_gains_out;
    status_word[`RCSS_ST_SERIAL] = cfg.serial_link_enable;
    status_word[`RCSS_ST_FIELDBUS] = fb_active;
    status_word[`RCSS_ST_CMD_LO +: 6] = drive_cmd_out;
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_link_drop;
    fb_active && !fieldbus_link_up_in;
  endsequence

  // reset seen high in the antecedent skips the edge at which reset is let go
  speed_ref_gate_a: assert property (
    reset_n_in && !cfg.speed_ref_remote_enable |=> speed_ref_out == $past(di_speed_ref_in))
    else $error("remote speed reference used while refused");
  dir_gate_a: assert property (
    reset_n_in && !cfg.direction_remote_enable
    |=> drive_cmd_out.direction == $past(di_cmd_in.direction))
    else $error("remote direction used while refused");
  release_wins_a: assert property (!di_release_in |=> drive_cmd_out.general_disable)
    else $error("drive released without hardwired input");
  gain_select_a: assert property (
    reset_n_in && cfg.aux_input_function == `RCSS_AUX_GAINS
    |=> secondary_gains_out == $past(aux_digital_input_in))
    else $error("gain set does not follow aux input");
  serial_src_a: assert property (
    cfg.aux_input_function == `RCSS_AUX_SERIAL && aux_digital_input_in
    |=> cmd_source_out == rcss_pkg::RCSS_SRC_SERIAL)
    else $error("serial source not taken");
  fieldbus_src_a: assert property (
    cfg.aux_input_function == `RCSS_AUX_FIELDBUS && !aux_digital_input_in
    |=> cmd_source_out == rcss_pkg::RCSS_SRC_DI)
    else $error("fieldbus source taken with aux input low");
  special_fn_a: assert property (
    cfg.aux_input_function == `RCSS_AUX_SPECIAL
    |=> cmd_source_out == rcss_pkg::RCSS_SRC_DI && !secondary_gains_out)
    else $error("reserved aux function changed selection");
  loss_flag_a: assert property (
    s_link_drop |=> bus_loss_fault_out ##1 (bus_loss_fault_out || $past(loss_clear)))
    else $error("bus loss not flagged");
  loss_action_a: assert property (
    bus_loss_fault_out && cfg.bus_loss_action == `RCSS_LOSS_RAMP |=> drive_cmd_out.ramp_disable)
    else $error("bus loss did not ramp disable");

endmodule

`default_nettype wire

// *** tb/rcss_far_end.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// far side: serial host and fieldbus master
// ****************************************************************
module rcss_far_end
(
  input wire logic sys_clk_in,
  input wire logic link_drop_in,
  output rcss_pkg::rcss_cmd_t serial_cmd_out,
  output logic [15:0] serial_speed_ref_out,
  output rcss_pkg::rcss_cmd_t fieldbus_cmd_out,
  output logic [15:0] fieldbus_speed_ref_out,
  output var logic fieldbus_link_up_out
);
  // distinct words per source so a wrong selection shows at once
  assign serial_cmd_out = 6'h1a;
  assign serial_speed_ref_out = 16'h5a5a;
  assign fieldbus_cmd_out = 6'h16;
  assign fieldbus_speed_ref_out = 16'hc3c3;

  // link drops one edge after the request, like a pulled cable
  always_ff @(posedge sys_clk_in)
  begin
    fieldbus_link_up_out <= !link_drop_in;
  end
endmodule

`default_nettype wire

// *** tb/rcss_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("MISMATCH %s expected %h seen %h", what, exp, got); \
    end \
  end

module rcss_top_tb;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic clk, rst_n, hsel, hwrite, hready, hresp, hw_release, link_up, link_drop, aux_in;
  logic [1:0] htrans;
  logic [2:0] hsize, fb_var;
  logic [31:0] haddr, hwdata, hrdata;
  logic [15:0] hw_speed, ser_speed, fb_speed, speed_ref, gprop, gint;
  logic sec_gains, tick, ser_act, fb_act, loss;
  logic [4:0] node;
  rcss_pkg::rcss_cmd_t hw_cmd, ser_cmd, fb_cmd, drive_cmd;
  rcss_pkg::rcss_src_t src;
  int fail_count, tests_run;

  rcss_top u_dut
  (
    .sys_clk_in(clk), .reset_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata),
    .di_cmd_in(hw_cmd), .di_speed_ref_in(hw_speed), .di_release_in(hw_release),
    .serial_cmd_in(ser_cmd), .serial_speed_ref_in(ser_speed),
    .fieldbus_cmd_in(fb_cmd), .fieldbus_speed_ref_in(fb_speed),
    .fieldbus_link_up_in(link_up), .aux_digital_input_in(aux_in),
    .drive_cmd_out(drive_cmd), .speed_ref_out(speed_ref), .cmd_source_out(src),
    .secondary_gains_out(sec_gains), .gain_prop_out(gprop), .gain_integral_out(gint),
    .serial_bit_tick_out(tick), .serial_link_active_out(ser_act),
    .fieldbus_active_out(fb_act), .fieldbus_variant_out(fb_var),
    .node_address_out(node), .bus_loss_fault_out(loss)
  );

  rcss_far_end u_far
  (
    .sys_clk_in(clk), .link_drop_in(link_drop), .serial_cmd_out(ser_cmd),
    .serial_speed_ref_out(ser_speed), .fieldbus_cmd_out(fb_cmd),
    .fieldbus_speed_ref_out(fb_speed), .fieldbus_link_up_out(link_up)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  // 50 ns period clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // one single-word transfer; hready is waited on, never assumed
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    `CHK(n, e, q)
  endtask

  // selection outputs lag config by one edge and a link drop by three, so four is settled
  task automatic settle;
    repeat (4) @(posedge clk);
  endtask

  // expected command mix: enabled groups from remote, release input always wins
  function automatic logic [5:0] mix(input logic [5:0] h, input logic [5:0] r,
                                     input logic [3:0] en, input logic rel);
    logic [5:0] m;
    m = h;
    if (en[1]) m[5:3] = r[5:3];
    if (en[2]) m[2] = r[2];
    if (en[3]) m[1:0] = r[1:0];
    m[5] = m[5] | !rel;
    return m;
  endfunction

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    rd_chk("cfg reset", 8'h00, 32'h0001_0000);
    rd_chk("unmapped read", 8'h10, 32'h0);
    `CHK("node reset", 5'h01, node)
    `CHK("source reset", rcss_pkg::RCSS_SRC_DI, src)
    `CHK("okay response", 1'b0, hresp)
  endtask

  task automatic t_gains;
    wr(8'h04, 32'h2222_1111);
    wr(8'h08, 32'h4444_3333);
    rd_chk("gain readback", 8'h04, 32'h2222_1111);
    aux_in <= 1'b0;
    settle();
    `CHK("primary prop", 16'h1111, gprop)
    aux_in <= 1'b1;
    settle();
    `CHK("secondary int", 16'h4444, gint)
    `CHK("secondary flag", 1'b1, sec_gains)
    // special function code must put gains back to primary and leave source alone
    wr(8'h00, 32'h20);
    settle();
    `CHK("special gains", 16'h1111, gprop)
    `CHK("special source", rcss_pkg::RCSS_SRC_DI, src)
  endtask

  task automatic t_serial;
    wr(8'h00, 32'h15);
    settle();
    `CHK("serial src", rcss_pkg::RCSS_SRC_SERIAL, src)
    `CHK("serial speed", ser_speed, speed_ref)
    `CHK("serial cmd", mix(hw_cmd, ser_cmd, 4'b0101, 1'b1), drive_cmd)
    aux_in <= 1'b0;
    settle();
    `CHK("local src", rcss_pkg::RCSS_SRC_DI, src)
    `CHK("local cmd", hw_cmd, drive_cmd)
  endtask

  task automatic t_fieldbus;
    wr(8'h00, 32'h3e);
    aux_in <= 1'b1;
    settle();
    `CHK("fb src", rcss_pkg::RCSS_SRC_FIELDBUS, src)
    `CHK("speed kept local", hw_speed, speed_ref)
    `CHK("fb cmd", mix(hw_cmd, fb_cmd, 4'b1110, 1'b1), drive_cmd)
    hw_release <= 1'b0;
    settle();
    `CHK("release held", mix(hw_cmd, fb_cmd, 4'b1110, 1'b0), drive_cmd)
    hw_release <= 1'b1;
    aux_in <= 1'b0;
  endtask

  task automatic t_tick;
    int n;
    wr(8'h00, 32'h100);
    n = 0;
    while (tick !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (tick !== 1'b1 && n < 3000);
    // 20 MHz over 9600 bit/s, rounded down
    `CHK("bit period", 2083, n)
    `CHK("serial active", 1'b1, ser_act)
    wr(8'h00, 32'h0);
  endtask

  task automatic t_fbsel;
    for (int v = 0; v < 7; v++)
    begin
      wr(8'h00, 32'(v) << 9);
      settle();
      `CHK("fb active", v != 0, fb_act)
      `CHK("fb variant", 3'(v), fb_var)
    end
    wr(8'h00, 32'h7 << 9);
    settle();
    `CHK("fb variant kept", 3'h6, fb_var)
  endtask

  task automatic t_loss;
    logic [5:0] e;
    for (int a = 0; a < 3; a++)
    begin
      wr(8'h00, (32'(a) << 12) | 32'h200);
      link_drop <= 1'b1;
      settle();
      e = hw_cmd;
      if (a == 0) e[4] = 1'b1;
      if (a == 1) e[5] = 1'b1;
      `CHK("loss flag", 1'b1, loss)
      `CHK("loss action", e, drive_cmd)
      rd_chk("status word", 8'h0c, {20'h0, e, 6'h21});
      link_drop <= 1'b0;
      settle();
      wr(8'h0c, 32'h1);
      settle();
      `CHK("loss cleared", 1'b0, loss)
    end
  endtask

  // ****************************************************************
  // run control
  // ****************************************************************
  task automatic close_out;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog sized well past the longest scenario, the bit period one
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end

  // main sequence
  initial
  begin
    fail_count = 0;
    tests_run = 0;
    rst_n = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    hw_cmd = 6'h05;
    hw_speed = 16'h1234;
    hw_release = 1'b1;
    link_drop = 1'b0;
    aux_in = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_gains();
    t_serial();
    t_fieldbus();
    t_tick();
    t_fbsel();
    t_loss();
    close_out();
  end
endmodule

`default_nettype wire
